// ---- rtl/jdi_debounce.sv ----
// millisecond debouncer for the combined jack level
`timescale 1ns/1ps
`default_nettype none
module jdi_debounce #(
  parameter int MS_CYC = 50000
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // control
  input wire logic clk_on,
  input wire logic skip,
  input wire logic restart,
  input wire logic init_level,
  input wire logic ins_level,
  input wire jdi_pkg::jdi_ms_t t_ins,
  input wire jdi_pkg::jdi_ms_t t_ej,
  // levels
  input wire logic raw,
  output logic stable
);
  localparam int TW = $clog2(MS_CYC + 1);
  logic [TW-1:0] tick_cnt;
  logic tick;
  jdi_pkg::jdi_ms_t ms_cnt;
  jdi_pkg::jdi_db_e st;
  jdi_pkg::jdi_ms_t target;

  // millisecond tick, idle while the debounce clock is off
  always_ff @(posedge ref_clk) begin
    if (!nrst || !clk_on) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == TW'(MS_CYC - 1));
      tick_cnt <= (tick_cnt == TW'(MS_CYC - 1)) ? '0 : tick_cnt + 1'b1;
    end
  end

  assign target = (raw == ins_level) ? t_ins : t_ej;

  // settle state machine
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st <= jdi_pkg::DB_HOLD;
      ms_cnt <= '0;
      stable <= 1'b1;
    end else if (restart) begin
      st <= jdi_pkg::DB_HOLD;
      ms_cnt <= '0;
      stable <= init_level;
    end else if (skip) begin
      st <= jdi_pkg::DB_HOLD;
      stable <= raw;
    end else begin
      case (st)
        jdi_pkg::DB_HOLD: begin
          ms_cnt <= '0;
          if (raw != stable) st <= jdi_pkg::DB_SETTLE;
        end
        jdi_pkg::DB_SETTLE: begin
          if (raw == stable) begin
            st <= jdi_pkg::DB_HOLD;
          end else if (tick) begin
            if (ms_cnt + 1'b1 >= target) begin
              stable <= raw;
              st <= jdi_pkg::DB_HOLD;
            end else begin
              ms_cnt <= ms_cnt + 1'b1;
            end
          end
        end
        default: st <= jdi_pkg::DB_HOLD;
      endcase
    end
  end
endmodule : jdi_debounce
`default_nettype wire

// ---- rtl/jdi_defines.svh ----
// offsets, field positions, reset values and timing of the jack/interrupt block
`ifndef JDI_DEFINES_SVH
`define JDI_DEFINES_SVH
`define JDI_OFF_JD 8'h0D
`define JDI_OFF_IRQ 8'h0F
`define JDI_OFF_STAT 8'h10
`define JDI_OFF_CLR 8'h11
`define JDI_OFF_DIS 8'h12
`define JDI_OFF_GPIO 8'h1A
`define JDI_OFF_DBCLK 8'h4B
`define JDI_RST_JD 16'h0000
`define JDI_RST_IRQ 16'h0000
`define JDI_RST_DIS 16'hFFFF
`define JDI_RST_GPIO 16'h0000
`define JDI_IRQ_WMASK 16'hFBF5
`define JDI_JD_SRC1 12
`define JDI_JD_RERUN 11
`define JDI_JD_SKIP 10
`define JDI_JD_INS 7
`define JDI_JD_EJ 4
`define JDI_JD_POL 3
`define JDI_JD_GATE 2
`define JDI_INTERRUPT_PIN_POLARITY 15
`define JDI_INTERRUPT_PIN_PULL_DIR 14
`define JDI_INTERRUPT_PIN_PULL_ON 13
`define JDI_INTERRUPT_PIN_DRIVE_STRENGTH 12
`define JDI_IRQ_OE 11
`define JDI_ST_INS 0
`define JDI_ST_EJ 2
`define JDI_ST_MIC 4
`define JDI_ST_SHD 9
`define JDI_P2_OUT 15
`define JDI_P2_PS 14
`define JDI_P2_DS 13
`define JDI_P2_PE 12
`define JDI_P2_OE 11
`define JDI_P1_POL 10
`define JDI_P1_SEL 7
`define JDI_P1_PS 6
`define JDI_P1_DS 5
`define JDI_P1_PE 4
`define JDI_P1_OE 3
`define JDI_CLK_NS 20
`define JDI_MS_NS 1000000
`endif

// ---- rtl/jdi_pkg.sv ----
// types shared by the jack/interrupt block
package jdi_pkg;
  typedef enum logic [0:0] {DB_HOLD, DB_SETTLE} jdi_db_e;
  typedef enum logic [2:0] {P1_ZERO, P1_JACK, P1_SCLK, P1_SDI, P1_LOOPCLK, P1_LOCK, P1_SDO, P1_OSC} jdi_p1fn_e;
  typedef logic [9:0] jdi_ms_t;
endpackage : jdi_pkg

// ---- rtl/jdi_sync.sv ----
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module jdi_sync #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // pins and synced levels
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  // two stages, first read only by second
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= pin_in;
      sync_out <= meta_reg;
    end
  end
endmodule : jdi_sync
`default_nettype wire

// ---- rtl/jdi_top.sv ----
// jack detection, event status and interrupt/general pin logic
`timescale 1ns/1ps
`default_nettype none
`include "jdi_defines.svh"
// Operation
// - source one is pin, inverted pin, forced 0 or forced 1 by two bits
// - skip bit zero debounces the jack input, one bypasses debouncing
// - insertion and ejection settle 2^(setting+2) milliseconds each
// - insertion on falling edge with polarity zero, rising edge with one
// - sources combine through OR at zero, AND at one
// - interrupt pin active low at polarity zero, active high at one
// - interrupt driver off until enabled; pull and strength bits default zero
// - every event source has a mask bit, one masks it
// - mask bits align with disable bits 9,8,7,6,5,4,2,0
// - ejection code 00 clear, 01 seen, 10 cleared by insertion
// - insertion code 00 clear, 01 seen, 10 cleared by ejection; read only
// - writing one to a clear bit zeroes matching status bit
// - clear bits 0 or 1 clear insertion field, 2 or 3 ejection field
// - disable bit one blocks status and pin; all reset to one
// - pin one function selected by three-bit code among eight sources
// - pin one polarity bit inverts the selected function
// - pin one pull direction counts only with pull on; driver enable not gated
// - pin two pull enable is active low, direction defaults up
// - pin two drives programmed value only while its driver is enabled
module jdi_top #(
  parameter int MS_CYC = (`JDI_MS_NS + `JDI_CLK_NS - 1) / `JDI_CLK_NS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // event pulses from the codec
  input wire logic mic_event,
  input wire logic lost_clock_event,
  input wire logic button_down_event,
  input wire logic button_up_event,
  input wire logic impedance_event,
  input wire logic shutdown_event,
  // asynchronous pin inputs
  input wire logic jack_pin_in,
  input wire logic pin_two_in,
  input wire logic serial_clk_in,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic loop_clk_div,
  input wire logic loop_locked,
  input wire logic osc_clk,
  // interrupt pin
  output logic irq_out,
  output logic irq_oe_n,
  output logic irq_pull_on,
  output logic irq_pull_dir,
  output logic irq_drive_hi,
  // pin one
  output logic pin_one_out,
  output logic pin_one_oe_n,
  output logic pin_one_pull_on,
  output logic pin_one_pull_dir,
  output logic pin_one_drive_hi,
  // pin two
  output logic pin_two_out,
  output logic pin_two_oe_n,
  output logic pin_two_pull_on,
  output logic pin_two_pull_dir,
  output logic pin_two_drive_hi
);
  logic [15:0] jd_reg;
  logic [15:0] irqcfg_reg;
  logic [15:0] dis_reg;
  logic [15:0] gpio_reg;
  logic dbclk_reg;
  logic restart_reg;
  logic [1:0] ins_reg;
  logic [1:0] ej_reg;
  logic [15:0] flag_reg;
  logic stable_q;
  logic [7:0] sync;
  logic [15:0] clr;
  logic [15:0] ev;
  logic [15:0] gate;
  logic [15:0] status;
  logic src1;
  logic comb;
  logic stable;
  logic ins_lvl;
  logic ins_ev;
  logic ej_ev;
  logic irq_act;
  logic p1_fn;
  logic [2:0] p1_sel;

  // settle time in ms for a setting
  function automatic jdi_pkg::jdi_ms_t settle_ms(input logic [2:0] e);
    // widen first so settings 6 and 7 do not wrap the shift amount
    settle_ms = jdi_pkg::jdi_ms_t'(10'h001 << (4'(e) + 4'h2));
  endfunction : settle_ms

  // pins into the clock domain
  jdi_sync #(.W(8)) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pin_in({jack_pin_in, pin_two_in, serial_clk_in, serial_data_in,
             serial_data_out, loop_clk_div, loop_locked, osc_clk}),
    .sync_out(sync)
  );

  always_comb begin
    case (jd_reg[`JDI_JD_SRC1+:2])
      2'h0: src1 = sync[6];
      2'h1: src1 = ~sync[6];
      2'h2: src1 = 1'b0;
      default: src1 = 1'b1;
    endcase
  end

  assign comb = jd_reg[`JDI_JD_GATE] ? (src1 & sync[7]) : (src1 | sync[7]);
  assign ins_lvl = jd_reg[`JDI_JD_POL];

  jdi_debounce #(.MS_CYC(MS_CYC)) u_deb (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clk_on(dbclk_reg),
    .skip(jd_reg[`JDI_JD_SKIP]),
    .restart(restart_reg),
    .init_level(~ins_lvl),
    .ins_level(ins_lvl),
    .t_ins(settle_ms(jd_reg[`JDI_JD_INS+:3])),
    .t_ej(settle_ms(jd_reg[`JDI_JD_EJ+:3])),
    .raw(comb),
    .stable(stable)
  );

  always_ff @(posedge ref_clk) begin
    if (!nrst) stable_q <= 1'b1;
    else stable_q <= stable;
  end
  assign ins_ev = (stable != stable_q) && (stable == ins_lvl);
  assign ej_ev = (stable != stable_q) && (stable != ins_lvl);

  // restart when rerun bit is written back to zero
  always_ff @(posedge ref_clk) begin
    if (!nrst) restart_reg <= 1'b0;
    else restart_reg <= reg_wr && (reg_addr == `JDI_OFF_JD)
                        && jd_reg[`JDI_JD_RERUN] && !reg_wdata[`JDI_JD_RERUN];
  end

  // control register writes
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      jd_reg <= `JDI_RST_JD;
      irqcfg_reg <= `JDI_RST_IRQ;
      dis_reg <= `JDI_RST_DIS;
      gpio_reg <= `JDI_RST_GPIO;
      dbclk_reg <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        `JDI_OFF_JD: jd_reg <= reg_wdata;
        `JDI_OFF_IRQ: irqcfg_reg <= reg_wdata & `JDI_IRQ_WMASK;
        `JDI_OFF_DIS: dis_reg <= reg_wdata;
        `JDI_OFF_GPIO: gpio_reg <= reg_wdata;
        `JDI_OFF_DBCLK: dbclk_reg <= reg_wdata[0];
        default: dbclk_reg <= dbclk_reg;
      endcase
    end
  end

  assign clr = (reg_wr && reg_addr == `JDI_OFF_CLR) ? reg_wdata : 16'h0000;
  assign ev = {6'h00, shutdown_event, impedance_event, button_up_event,
               button_down_event, lost_clock_event, mic_event, 4'h0};
  assign gate = ~dis_reg & ~irqcfg_reg;

  // single-bit flags, set wins over clear
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      flag_reg <= 16'h0000;
    end else begin
      for (int i = `JDI_ST_MIC; i <= `JDI_ST_SHD; i++) begin
        flag_reg[i] <= (flag_reg[i] & ~clr[i]) | (ev[i] & ~dis_reg[i]);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) ins_reg <= 2'h0;
    else if (ins_ev && !dis_reg[`JDI_ST_INS]) ins_reg <= 2'h1;
    else if (ej_ev && ins_reg == 2'h1) ins_reg <= 2'h2;
    else if (|clr[1:0]) ins_reg <= 2'h0;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) ej_reg <= 2'h0;
    else if (ej_ev && !dis_reg[`JDI_ST_EJ]) ej_reg <= 2'h1;
    else if (ins_ev && ej_reg == 2'h1) ej_reg <= 2'h2;
    else if (|clr[3:2]) ej_reg <= 2'h0;
  end

  assign status = {flag_reg[15:4], ej_reg, ins_reg};

  assign irq_act = ((|ins_reg) & gate[`JDI_ST_INS])
                 | ((|ej_reg) & gate[`JDI_ST_EJ])
                 | (|(flag_reg[9:4] & gate[9:4]));

  // register read-back, unmapped reads zero
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `JDI_OFF_JD: reg_rdata <= jd_reg;
        `JDI_OFF_IRQ: reg_rdata <= irqcfg_reg;
        `JDI_OFF_STAT: reg_rdata <= status;
        `JDI_OFF_DIS: reg_rdata <= dis_reg;
        `JDI_OFF_GPIO: reg_rdata <= gpio_reg;
        `JDI_OFF_DBCLK: reg_rdata <= {15'h0000, dbclk_reg};
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  assign p1_sel = gpio_reg[`JDI_P1_SEL+:3];
  always_comb begin
    case (jdi_pkg::jdi_p1fn_e'(p1_sel))
      jdi_pkg::P1_ZERO: p1_fn = 1'b0;
      jdi_pkg::P1_JACK: p1_fn = comb;
      jdi_pkg::P1_SCLK: p1_fn = sync[5];
      jdi_pkg::P1_SDI: p1_fn = sync[4];
      jdi_pkg::P1_LOOPCLK: p1_fn = sync[2];
      jdi_pkg::P1_LOCK: p1_fn = sync[1];
      jdi_pkg::P1_SDO: p1_fn = sync[3];
      default: p1_fn = sync[0];
    endcase
  end

  // interrupt pin drive
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      irq_out <= 1'b1;
      irq_oe_n <= 1'b1;
      irq_pull_on <= 1'b0;
      irq_pull_dir <= 1'b0;
      irq_drive_hi <= 1'b0;
    end else begin
      irq_out <= irqcfg_reg[`JDI_INTERRUPT_PIN_POLARITY] ? irq_act : ~irq_act;
      irq_oe_n <= ~irqcfg_reg[`JDI_IRQ_OE];
      irq_pull_on <= irqcfg_reg[`JDI_INTERRUPT_PIN_PULL_ON];
      irq_pull_dir <= irqcfg_reg[`JDI_INTERRUPT_PIN_PULL_DIR];
      irq_drive_hi <= irqcfg_reg[`JDI_INTERRUPT_PIN_DRIVE_STRENGTH];
    end
  end

  // general pin drive
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pin_one_out <= 1'b0;
      pin_one_oe_n <= 1'b1;
      pin_one_pull_on <= 1'b0;
      pin_one_pull_dir <= 1'b0;
      pin_one_drive_hi <= 1'b0;
      pin_two_out <= 1'b0;
      pin_two_oe_n <= 1'b1;
      pin_two_pull_on <= 1'b1;
      pin_two_pull_dir <= 1'b0;
      pin_two_drive_hi <= 1'b0;
    end else begin
      pin_one_out <= p1_fn ^ gpio_reg[`JDI_P1_POL];
      // pull direction only with pull on
      pin_one_oe_n <= ~gpio_reg[`JDI_P1_OE];
      pin_one_pull_on <= gpio_reg[`JDI_P1_PE];
      pin_one_pull_dir <= gpio_reg[`JDI_P1_PE] & gpio_reg[`JDI_P1_PS];
      pin_one_drive_hi <= gpio_reg[`JDI_P1_DS];
      pin_two_out <= gpio_reg[`JDI_P2_OUT];
      pin_two_oe_n <= ~gpio_reg[`JDI_P2_OE];
      pin_two_pull_on <= ~gpio_reg[`JDI_P2_PE];
      pin_two_pull_dir <= gpio_reg[`JDI_P2_PS];
      pin_two_drive_hi <= gpio_reg[`JDI_P2_DS];
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  property p_src_force;
    jd_reg[`JDI_JD_SRC1+:2] == 2'h3 |-> src1;
  endproperty
  a_src_force: assert property (p_src_force) else $error("forced source not one");

  property p_skip;
    jd_reg[`JDI_JD_SKIP] && !restart_reg ##1 jd_reg[`JDI_JD_SKIP] |-> stable == $past(comb);
  endproperty
  a_skip: assert property (p_skip) else $error("bypass did not follow input");

  property p_ins_code;
    ins_ev && !dis_reg[0] |=> ins_reg == 2'h1 ##1 (ins_reg != 2'h0 || $past(|clr[1:0]));
  endproperty
  a_ins_code: assert property (p_ins_code) else $error("insertion code wrong");

  property p_ej_over;
    ej_reg == 2'h1 && ins_ev && !ej_ev |=> ej_reg == 2'h2;
  endproperty
  a_ej_over: assert property (p_ej_over) else $error("ejection not overtaken");

  property p_clear_field;
    clr[1] && !ins_ev && !ej_ev |=> ins_reg == 2'h0;
  endproperty
  a_clear_field: assert property (p_clear_field) else $error("insertion field kept");

  property p_clear_bit;
    clr[5] && !lost_clock_event |=> !status[5];
  endproperty
  a_clear_bit: assert property (p_clear_bit) else $error("flag not cleared");

  property p_disabled;
    dis_reg[4] && !status[4] |=> !status[4];
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled flag set");

  property p_irq_level;
    ##1 1'b1 |-> irq_out == ($past(irqcfg_reg[`JDI_INTERRUPT_PIN_POLARITY]) ~^ $past(irq_act));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt pin level wrong");

  property p_irq_drive;
    !irqcfg_reg[`JDI_IRQ_OE] [*2] |-> irq_oe_n;
  endproperty
  a_irq_drive: assert property (p_irq_drive) else $error("interrupt driver on");

  property p_pin1;
    p1_sel == 3'h0 |=> pin_one_out == $past(gpio_reg[`JDI_P1_POL]);
  endproperty
  a_pin1: assert property (p_pin1) else $error("pin one value wrong");

  property p_pull1;
    !gpio_reg[`JDI_P1_PE] |=> !pin_one_pull_dir;
  endproperty
  a_pull1: assert property (p_pull1) else $error("pull direction without pull");

  property p_pin2;
    gpio_reg[`JDI_P2_OE] && !gpio_reg[`JDI_P2_PE] |=> !pin_two_oe_n && pin_two_pull_on;
  endproperty
  a_pin2: assert property (p_pin2) else $error("pin two drive wrong");

  c_insert: cover property (ins_ev ##1 ins_reg == 2'h1);
  c_eject: cover property (ej_ev ##1 ej_reg == 2'h1);
  c_irq: cover property (!irq_act ##1 irq_act);
  c_restart: cover property (restart_reg);
endmodule : jdi_top
`default_nettype wire

// ---- testbench/jdi_partner.sv ----
// jack switch and host interrupt input model
`timescale 1ns/1ps
`default_nettype none
module jdi_partner (
  // clock
  input wire logic ref_clk,
  // plug state and detect line
  input wire logic plugged,
  output logic jack_pin_in,
  // interrupt pad as the host sees it
  input wire logic irq_out,
  input wire logic irq_oe_n,
  input wire logic irq_pull_on,
  input wire logic irq_pull_dir,
  output logic irq_level
);
  logic last_reg = 1'b1;
  // switch contact grounds the line while a plug sits in the jack
  assign jack_pin_in = ~plugged;
  // last value the codec drove onto the pad
  always_ff @(posedge ref_clk) begin
    if (!irq_oe_n) begin
      last_reg <= irq_out;
    end
  end
  // released pad: pull level, else the inverse of the last driven value
  assign irq_level = !irq_oe_n ? irq_out : (irq_pull_on ? irq_pull_dir : ~last_reg);
endmodule : jdi_partner
`default_nettype wire

// ---- testbench/jdi_top_test.sv ----
// self-checking bench for the jack and interrupt block
`timescale 1ns/1ps
`default_nettype none
module jdi_top_test;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata, rd_val;
  logic [5:0] ev = 6'h00;
  logic [5:0] mux_src = 6'h00;
  logic plugged = 1'b0;
  logic pin_two_in = 1'b1;
  logic jack_pin_in, irq_out, irq_oe_n, irq_pull_on, irq_pull_dir, irq_drive_hi, irq_level;
  logic pin_one_out, pin_one_oe_n, pin_one_pull_on, pin_one_pull_dir, pin_one_drive_hi;
  logic pin_two_out, pin_two_oe_n, pin_two_pull_on, pin_two_pull_dir, pin_two_drive_hi;
  int failures = 0;
  int total_checks = 0;

  // block under test with a short millisecond tick
  jdi_top #(.MS_CYC(4)) jdi_top_i (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mic_event(ev[0]), .lost_clock_event(ev[1]),
    .button_down_event(ev[2]), .button_up_event(ev[3]), .impedance_event(ev[4]), .shutdown_event(ev[5]),
    .jack_pin_in(jack_pin_in), .pin_two_in(pin_two_in), .serial_clk_in(mux_src[0]),
    .serial_data_in(mux_src[1]), .loop_clk_div(mux_src[2]), .loop_locked(mux_src[3]),
    .serial_data_out(mux_src[4]), .osc_clk(mux_src[5]), .irq_out(irq_out), .irq_oe_n(irq_oe_n),
    .irq_pull_on(irq_pull_on), .irq_pull_dir(irq_pull_dir), .irq_drive_hi(irq_drive_hi),
    .pin_one_out(pin_one_out), .pin_one_oe_n(pin_one_oe_n), .pin_one_pull_on(pin_one_pull_on),
    .pin_one_pull_dir(pin_one_pull_dir), .pin_one_drive_hi(pin_one_drive_hi), .pin_two_out(pin_two_out),
    .pin_two_oe_n(pin_two_oe_n), .pin_two_pull_on(pin_two_pull_on), .pin_two_pull_dir(pin_two_pull_dir),
    .pin_two_drive_hi(pin_two_drive_hi)
  );

  // jack switch and host side
  jdi_partner jdi_partner_i (
    .ref_clk(ref_clk), .plugged(plugged), .jack_pin_in(jack_pin_in), .irq_out(irq_out),
    .irq_oe_n(irq_oe_n), .irq_pull_on(irq_pull_on), .irq_pull_dir(irq_pull_dir), .irq_level(irq_level)
  );

  // 50 MHz clock
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic nap(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : nap

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask : rd

  task automatic plug(input logic v);
    @(posedge ref_clk);
    plugged <= v;
  endtask : plug

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  task automatic test_reset();
    logic [7:0] addrs [7] = '{8'h0D, 8'h0F, 8'h12, 8'h1A, 8'h11, 8'h4B, 8'h33};
    logic [15:0] exps [7] = '{16'h0000, 16'h0000, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    nap(1);
    chk("pads", 16'h0047, {9'h000, irq_oe_n, irq_pull_on, irq_pull_dir, irq_drive_hi, pin_one_oe_n,
        pin_two_pull_on, pin_two_oe_n});
    for (int k = 0; k < 7; k++) begin
      rd(addrs[k]);
      chk("reset read", exps[k], rd_val);
    end
    $display("reset test done");
  endtask : test_reset

  task automatic test_events();
    logic [15:0] b;
    for (int i = 0; i < 6; i++) begin
      b = 16'h0010 << i;
      ev <= 6'h01 << i;
      nap(1);
      ev <= 6'h00;
      rd(8'h10);
      chk("disabled", 16'h0000, rd_val);
      wr(8'h12, ~b);
      wr(8'h0F, 16'h0800);
      ev <= 6'h01 << i;
      nap(1);
      ev <= 6'h00;
      rd(8'h10);
      chk("status", b, rd_val);
      chk("irq low", 16'h0000, {15'h0000, irq_level});
      wr(8'h0F, 16'h8800);
      nap(2);
      chk("irq high", 16'h0001, {15'h0000, irq_level});
      wr(8'h0F, 16'h8800 | b);
      nap(2);
      chk("irq masked", 16'h0000, {15'h0000, irq_level});
      wr(8'h11, b);
      rd(8'h10);
      chk("cleared", 16'h0000, rd_val);
      wr(8'h12, 16'hFFFF);
    end
    wr(8'h10, 16'h03F0);
    rd(8'h10);
    chk("read only", 16'h0000, rd_val);
    $display("events test done");
  endtask : test_events

  task automatic test_jack();
    wr(8'h12, 16'h0000);
    wr(8'h0F, 16'h0000);
    wr(8'h0D, 16'h3400);
    plug(1'b1);
    nap(6);
    rd(8'h10);
    chk("forced one", 16'h0000, rd_val);
    wr(8'h0D, 16'h2400);
    nap(6);
    rd(8'h10);
    chk("insertion", 16'h0001, rd_val);
    wr(8'h0D, 16'h3404);
    nap(4);
    rd(8'h10);
    chk("and gate", 16'h0001, rd_val);
    plug(1'b0);
    nap(6);
    rd(8'h10);
    chk("ejection", 16'h0006, rd_val);
    wr(8'h11, 16'h0002);
    rd(8'h10);
    chk("clr ins", 16'h0004, rd_val);
    wr(8'h11, 16'h0008);
    rd(8'h10);
    chk("clr ej", 16'h0000, rd_val);
    plug(1'b1);
    nap(6);
    wr(8'h11, 16'h000F);
    wr(8'h0D, 16'h3C04);
    wr(8'h0D, 16'h3404);
    nap(6);
    rd(8'h10);
    chk("rerun", 16'h0001, rd_val & 16'h0003);
    plug(1'b0);
    nap(6);
    $display("jack test done");
  endtask : test_jack

  task automatic test_debounce();
    wr(8'h4B, 16'h0001);
    wr(8'h0D, 16'h3014);
    nap(40);
    wr(8'h11, 16'h000F);
    plug(1'b1);
    nap(8);
    rd(8'h10);
    chk("ins early", 16'h0000, rd_val & 16'h0003);
    nap(14);
    rd(8'h10);
    chk("ins late", 16'h0001, rd_val & 16'h0003);
    wr(8'h11, 16'h000F);
    plug(1'b0);
    nap(20);
    rd(8'h10);
    chk("ej early", 16'h0000, rd_val & 16'h000C);
    nap(20);
    rd(8'h10);
    chk("ej late", 16'h0004, rd_val & 16'h000C);
    $display("debounce test done");
  endtask : test_debounce

  task automatic test_pins();
    logic p;
    wr(8'h1A, 16'h0040);
    nap(2);
    chk("pull gated", 16'h0000, {14'h0000, pin_one_pull_on, pin_one_pull_dir});
    wr(8'h1A, 16'h0050);
    nap(2);
    chk("pull down", 16'h0003, {14'h0000, pin_one_pull_on, pin_one_pull_dir});
    for (int c = 0; c < 8; c++) begin
      for (int v = 0; v < 2; v++) begin
        mux_src <= (c >= 2) ? (6'h01 << (c - 2)) : 6'h00;
        wr(8'h1A, 16'h0008 | (16'(c) << 7) | (16'(v) << 10));
        nap(4);
        if (c == 1 && v == 0) p = pin_one_out;
        if (c != 1) chk("pin one", {15'h0000, (c >= 2) ^ v[0]}, {15'h0000, pin_one_out});
        else if (v == 1) chk("pin one jack", {15'h0000, ~p}, {15'h0000, pin_one_out});
      end
    end
    chk("pin one drive", 16'h0000, {15'h0000, pin_one_oe_n});
    wr(8'h1A, 16'h9800);
    nap(2);
    chk("pin two", 16'h000C, {12'h000, pin_one_oe_n, pin_two_out, pin_two_pull_on, pin_two_oe_n});
    wr(8'h0F, 16'h7400);
    wr(8'h1A, 16'h6020);
    nap(2);
    chk("pad settings", 16'h00FF, {8'h00, irq_oe_n, irq_pull_on, irq_pull_dir, irq_drive_hi, irq_level,
        pin_one_drive_hi, pin_two_pull_dir, pin_two_drive_hi});
    rd(8'h0F);
    chk("irq cfg read", 16'h7000, rd_val);
    rd(8'h1A);
    chk("pin cfg read", 16'h6020, rd_val);
    $display("pins test done");
  endtask : test_pins

  // reset, then the scenarios in turn
  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    test_reset();
    test_events();
    test_jack();
    test_debounce();
    test_pins();
    complete_run();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    complete_run();
  end
endmodule : jdi_top_test
`default_nettype wire
